/* dbg_ports.sv */
// Purpose: Two byte-wide general-purpose ports with per-pin direction
// Assumes: Registers reached over a byte address, read and write strobe
// Notes: Pins are split into input, output and output enable
`timescale 1ns/1ps
module dbg_ports
    import dbg_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_srst,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    input  wire logic [1:0] i_if_mode,
    input  wire logic       i_serial_mode,
    input  wire logic [7:0] i_port_one_pins,
    output logic      [7:0] o_port_one_pins,
    output logic      [7:0] o_port_one_pins_oe,
    output logic            o_port_one_pullup_en,
    input  wire logic [7:0] i_port_two_pins,
    output logic      [7:0] o_port_two_pins,
    output logic      [7:0] o_port_two_pins_oe,
    output logic            o_port_two_pullup_en
);
    logic [7:0] port_one_direction_reg;
    logic [7:0] port_two_direction_reg;
    logic [7:0] port_one_drive_levels_reg;
    logic [7:0] port_two_drive_levels_reg;
    logic [7:0] port_one_pin_levels;
    logic [7:0] port_two_pin_levels;
    logic       gpio_mode;

    // Port one is general purpose only when the upper bus lines are free
    assign gpio_mode = i_serial_mode || (i_if_mode == DBG_MODE_MUX8)
                       || (i_if_mode == DBG_MODE_MUX8_ALT);

    // Level registers are the synchroniser outputs; no write path exists
    dbg_sync #(.WIDTH(DBG_WIDTH)) u_sync_one (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_async    (i_port_one_pins),
        .o_sync     (port_one_pin_levels)
    );
    dbg_sync #(.WIDTH(DBG_WIDTH)) u_sync_two (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_async    (i_port_two_pins),
        .o_sync     (port_two_pin_levels)
    );

    // Direction registers, cleared so every pin starts as an input
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            port_one_direction_reg <= DBG_RST_DIR;
            port_two_direction_reg <= DBG_RST_DIR;
        end
        else if (i_reg_wr)
        begin
            if (i_reg_addr == DBG_OFS_P1_DIR)
                port_one_direction_reg <= i_reg_wdata;
            if (i_reg_addr == DBG_OFS_P2_DIR)
                port_two_direction_reg <= i_reg_wdata;
        end
    end

    // Drive registers hold their value whatever the direction
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            port_one_drive_levels_reg <= DBG_RST_DRV;
            port_two_drive_levels_reg <= DBG_RST_DRV;
        end
        else if (i_reg_wr)
        begin
            if (i_reg_addr == DBG_OFS_P1_DRV)
                port_one_drive_levels_reg <= i_reg_wdata;
            if (i_reg_addr == DBG_OFS_P2_DRV)
                port_two_drive_levels_reg <= i_reg_wdata;
        end
    end

    // Each pull-up drops on the first write to its own port's direction register and stays off until reset
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            o_port_one_pullup_en <= DBG_RST_PULLUP;
            o_port_two_pullup_en <= DBG_RST_PULLUP;
        end
        else if (i_reg_wr)
        begin
            if (i_reg_addr == DBG_OFS_P1_DIR)
                o_port_one_pullup_en <= 1'b0;
            if (i_reg_addr == DBG_OFS_P2_DIR)
                o_port_two_pullup_en <= 1'b0;
        end
    end

    // Pin drivers registered: enable two cycles after a direction write; port one's enable stays clear unless gpio_mode
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            o_port_one_pins    <= DBG_RST_DRV;
            o_port_one_pins_oe <= DBG_RST_DIR;
            o_port_two_pins    <= DBG_RST_DRV;
            o_port_two_pins_oe <= DBG_RST_DIR;
        end
        else
        begin
            o_port_one_pins    <= port_one_drive_levels_reg;
            o_port_one_pins_oe <= gpio_mode ? port_one_direction_reg : 8'h00;
            o_port_two_pins    <= port_two_drive_levels_reg;
            o_port_two_pins_oe <= port_two_direction_reg;
        end
    end

    // Read data registered; one cycle after the read strobe
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
            o_reg_rdata <= DBG_RDATA_UNMAP;
        else if (i_reg_rd)
        begin
            case (i_reg_addr)
                DBG_OFS_P1_DIR: o_reg_rdata <= port_one_direction_reg;
                DBG_OFS_P2_DIR: o_reg_rdata <= port_two_direction_reg;
                DBG_OFS_P1_LVL: o_reg_rdata <= port_one_pin_levels;
                DBG_OFS_P2_LVL: o_reg_rdata <= port_two_pin_levels;
                DBG_OFS_P1_DRV: o_reg_rdata <= port_one_drive_levels_reg;
                DBG_OFS_P2_DRV: o_reg_rdata <= port_two_drive_levels_reg;
                default:        o_reg_rdata <= DBG_RDATA_UNMAP;
            endcase
        end
    end

    // Checks
    property p_dir_write_enables;
        @(posedge i_core_clk) disable iff (i_srst)
        (i_reg_wr && i_reg_addr == DBG_OFS_P2_DIR) |=> ##1
            (o_port_two_pins_oe == $past(i_reg_wdata, 2));
    endproperty
    a_dir_write_enables: assert property (p_dir_write_enables)
        else $error("port two enable does not follow direction write");

    property p_undriven_when_input;
        @(posedge i_core_clk) disable iff (i_srst)
        (port_one_direction_reg == 8'h00) |=> (o_port_one_pins_oe == 8'h00);
    endproperty
    a_undriven_when_input: assert property (p_undriven_when_input)
        else $error("port one driven while all pins are inputs");

    property p_drive_follows;
        @(posedge i_core_clk) disable iff (i_srst)
        (i_reg_wr && i_reg_addr == DBG_OFS_P1_DRV) |=> ##1
            (o_port_one_pins == $past(i_reg_wdata, 2));
    endproperty
    a_drive_follows: assert property (p_drive_follows)
        else $error("port one pin level does not follow drive register");

    property p_pullup_off;
        @(posedge i_core_clk) disable iff (i_srst)
        (i_reg_wr && i_reg_addr == DBG_OFS_P1_DIR) |=> !o_port_one_pullup_en;
    endproperty
    a_pullup_off: assert property (p_pullup_off)
        else $error("port one pull-ups still on after direction write");

    property p_mode_gate;
        @(posedge i_core_clk) disable iff (i_srst)
        !gpio_mode |=> (o_port_one_pins_oe == 8'h00);
    endproperty
    a_mode_gate: assert property (p_mode_gate)
        else $error("port one driven in a bus mode");

    property p_level_read;
        @(posedge i_core_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == DBG_OFS_P1_LVL) |=>
            (o_reg_rdata == $past(i_port_one_pins, 3));
    endproperty
    a_level_read: assert property (p_level_read)
        else $error("port one level read not the synchronised pin");

    property p_level_read_two;
        @(posedge i_core_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == DBG_OFS_P2_LVL) |=>
            (o_reg_rdata == $past(i_port_two_pins, 3));
    endproperty
    a_level_read_two: assert property (p_level_read_two)
        else $error("port two level read not the synchronised pin");

    property p_reset_values;
        @(posedge i_core_clk)
        i_srst |=> (o_port_one_pins_oe == 8'h00 && o_port_two_pins == 8'h00
                    && o_port_one_pullup_en);
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("reset values wrong");

    // A later write only reaches the pins one edge after this check looks
    property p_dir_one_enables;
        @(posedge i_core_clk) disable iff (i_srst)
        (i_reg_wr && i_reg_addr == DBG_OFS_P1_DIR) ##1 gpio_mode
            |=> (o_port_one_pins_oe == $past(i_reg_wdata, 2));
    endproperty
    a_dir_one_enables: assert property (p_dir_one_enables)
        else $error("port one enable does not follow direction write");

    property p_pullup_two_off;
        @(posedge i_core_clk) disable iff (i_srst)
        (i_reg_wr && i_reg_addr == DBG_OFS_P2_DIR) |=> !o_port_two_pullup_en;
    endproperty
    a_pullup_two_off: assert property (p_pullup_two_off)
        else $error("port two pull-ups still on after direction write");

    property p_drive_two_follows;
        @(posedge i_core_clk) disable iff (i_srst)
        (i_reg_wr && i_reg_addr == DBG_OFS_P2_DRV) |=> ##1
            (o_port_two_pins == $past(i_reg_wdata, 2));
    endproperty
    a_drive_two_follows: assert property (p_drive_two_follows)
        else $error("port two pin level does not follow drive register");

    // Direction changes must never disturb the stored drive level
    property p_drive_hold;
        @(posedge i_core_clk) disable iff (i_srst)
        !(i_reg_wr && i_reg_addr == DBG_OFS_P1_DRV)
            |=> (port_one_drive_levels_reg == $past(port_one_drive_levels_reg));
    endproperty
    a_drive_hold: assert property (p_drive_hold)
        else $error("port one drive register changed without a write");
endmodule // dbg_ports

/* dbg_pkg.sv */
// Purpose: Constants for the dual byte general-purpose port block
// Assumes: Register access over a simple byte-wide address/strobe port
// Notes: Offsets are byte addresses on the register port
package dbg_pkg;
    localparam int         DBG_WIDTH         = 8;
    localparam logic [7:0] DBG_OFS_P1_DIR    = 8'h9F;
    localparam logic [7:0] DBG_OFS_P2_DIR    = 8'hAF;
    localparam logic [7:0] DBG_OFS_P1_LVL    = 8'hBF;
    localparam logic [7:0] DBG_OFS_P2_LVL    = 8'hCF;
    localparam logic [7:0] DBG_OFS_P1_DRV    = 8'hDF;
    localparam logic [7:0] DBG_OFS_P2_DRV    = 8'hEF;
    localparam logic [7:0] DBG_RST_DIR       = 8'h00;
    localparam logic [7:0] DBG_RST_LVL       = 8'hFF;
    localparam logic [7:0] DBG_RST_DRV       = 8'h00;
    localparam logic [7:0] DBG_RDATA_UNMAP   = 8'h00;
    localparam logic       DBG_RST_PULLUP    = 1'b1;
    // Interface mode codes on the two mode straps
    localparam logic [1:0] DBG_MODE_MUX8     = 2'h0;
    localparam logic [1:0] DBG_MODE_MUX8_ALT = 2'h2;
endpackage : dbg_pkg

/* dbg_sync.sv */
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Single clock, synchronous active-high reset
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module dbg_sync
    import dbg_pkg::*;
#(
    parameter int WIDTH = DBG_WIDTH
)
(
    input  wire logic             i_core_clk,
    input  wire logic             i_srst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;

    // Both stages reset to ones so the level register reads high after reset
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            meta_reg <= WIDTH'(DBG_RST_LVL);
            o_sync   <= WIDTH'(DBG_RST_LVL);
        end
        else
        begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule // dbg_sync

/* dbg_pin_partner.sv */
// Purpose: Far-side circuitry resolving one port's pins
// Assumes: Bench sets far-side drive enables and levels
// Notes: A floating pin with no pull-up drifts to the inverse of its last level
`timescale 1ns/1ps
module dbg_pin_partner
(
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_dut_out,
    input  wire logic [7:0] i_dut_oe,
    input  wire logic       i_pullup_en,
    input  wire logic [7:0] i_ext_en,
    input  wire logic [7:0] i_ext_val,
    output logic      [7:0] o_wire
);
    logic [7:0] last_q;
    // Last level kept so a released line never looks held
    always_ff @(posedge i_core_clk)
        last_q <= o_wire;
    // Design wins, then far side, then pull-up, else drift
    always_comb
        for (int b = 0; b < 8; b++)
            o_wire[b] = i_dut_oe[b] ? i_dut_out[b] : i_ext_en[b] ? i_ext_val[b] :
                        i_pullup_en ? 1'b1 : ~last_q[b];
endmodule // dbg_pin_partner

/* tb.sv */
// Purpose: Self-checking bench for the dual byte port block
// Assumes: Inputs driven on the falling edge
// Notes: Level reads wait four cycles so both sync flops settle
`timescale 1ns/1ps
module tb;
    import dbg_pkg::*;
    logic i_core_clk = 0, i_srst = 1, i_reg_wr = 0, i_reg_rd = 0, i_serial_mode = 0;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
    logic [1:0] i_if_mode = 2'h0;
    wire logic [1:0][7:0] pin_in, pin_out, pin_oe;
    wire logic [1:0]      pu;
    logic      [1:0][7:0] ext_en, ext_val;
    int         bad_count = 0, check_count = 0, m_dir [2], m_drv [2];
    logic [7:0] dir_a [2] = '{DBG_OFS_P1_DIR, DBG_OFS_P2_DIR};
    logic [7:0] drv_a [2] = '{DBG_OFS_P1_DRV, DBG_OFS_P2_DRV};
    logic [7:0] lvl_a [2] = '{DBG_OFS_P1_LVL, DBG_OFS_P2_LVL};
    // Built from the constants: static initialisers have no defined order
    logic [7:0] ra [7] = '{DBG_OFS_P1_DIR, DBG_OFS_P2_DIR, DBG_OFS_P1_LVL, DBG_OFS_P2_LVL,
                           DBG_OFS_P1_DRV, DBG_OFS_P2_DRV, 8'h10};
    logic [7:0] rv [7] = '{DBG_RST_DIR, DBG_RST_DIR, DBG_RST_LVL, DBG_RST_LVL,
                           DBG_RST_DRV, DBG_RST_DRV, DBG_RDATA_UNMAP};
    // Clock at 200 MHz
    always #2.5 i_core_clk = ~i_core_clk;
    dbg_ports dut_u (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_if_mode(i_if_mode), .i_serial_mode(i_serial_mode),
        .i_port_one_pins(pin_in[0]), .o_port_one_pins(pin_out[0]),
        .o_port_one_pins_oe(pin_oe[0]), .o_port_one_pullup_en(pu[0]),
        .i_port_two_pins(pin_in[1]), .o_port_two_pins(pin_out[1]),
        .o_port_two_pins_oe(pin_oe[1]), .o_port_two_pullup_en(pu[1]));
    dbg_pin_partner p1_u (.i_core_clk(i_core_clk), .i_dut_out(pin_out[0]),
        .i_dut_oe(pin_oe[0]), .i_pullup_en(pu[0]), .i_ext_en(ext_en[0]),
        .i_ext_val(ext_val[0]), .o_wire(pin_in[0]));
    dbg_pin_partner p2_u (.i_core_clk(i_core_clk), .i_dut_out(pin_out[1]),
        .i_dut_oe(pin_oe[1]), .i_pullup_en(pu[1]), .i_ext_en(ext_en[1]),
        .i_ext_val(ext_val[1]), .o_wire(pin_in[1]));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle strobes; an idle cycle after a write so the strobe never falls and rises at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_reg_wr = 1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(negedge i_core_clk) i_reg_wr = 0;
        @(negedge i_core_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        i_reg_rd = 1;
        i_reg_addr = a;
        @(negedge i_core_clk) i_reg_rd = 0;
        @(negedge i_core_clk) d = o_reg_rdata;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Watchdog against a hung run
    initial
    begin
        #50000;
        bad_count++;
        wrap_up();
    end
    // Reset values, pull-up release, then random traffic against the model
    initial
    begin
        logic [7:0] d;
        logic [7:0] oe_x;
        logic       g;
        ext_en = '0;
        ext_val = '0;
        void'($urandom(32'hd2d5));
        repeat (2) @(negedge i_core_clk);
        i_srst = 0;
        chk(pin_oe[0] | pin_oe[1], 8'h00);
        for (int i = 0; i < 7; i++)
        begin
            rd(ra[i], d);
            chk(d, rv[i]);
        end
        wr(DBG_OFS_P1_DIR, 8'h00);
        repeat (3) @(negedge i_core_clk);
        chk({6'h00, pu[0], pu[1]}, 8'h01);
        for (int n = 0; n < 40; n++)
        begin
            i_if_mode = 2'($urandom);
            i_serial_mode = 1'($urandom);
            g = (i_if_mode == 2'h0) || (i_if_mode == 2'h2) || i_serial_mode;
            for (int p = 0; p < 2; p++)
            begin
                ext_en[p] = 8'hFF;
                ext_val[p] = 8'($urandom);
                m_dir[p] = $urandom % 256;
                wr(dir_a[p], 8'(m_dir[p]));
                // Odd passes keep the old drive value to show it is retained
                if (n % 2 == 0)
                    m_drv[p] = $urandom % 256;
                if (n % 2 == 0)
                    wr(drv_a[p], 8'(m_drv[p]));
                wr(lvl_a[p], 8'($urandom));
            end
            repeat (4) @(negedge i_core_clk);
            for (int p = 0; p < 2; p++)
            begin
                oe_x = 8'(m_dir[p]) & ((p == 1 || g) ? 8'hFF : 8'h00);
                chk(pin_oe[p], oe_x);
                chk(pin_out[p], 8'(m_drv[p]));
                chk({7'h00, pu[p]}, 8'h00);
                rd(lvl_a[p], d);
                chk(d, (oe_x & 8'(m_drv[p])) | (~oe_x & ext_val[p]));
                rd(dir_a[p], d);
                chk(d, 8'(m_dir[p]));
                rd(drv_a[p], d);
                chk(d, 8'(m_drv[p]));
            end
        end
        wrap_up();
    end
endmodule // tb
